// >>> ccm_chk_asserts.sv
// concurrent checks on the ports of the cpu clock mode selector
`timescale 1ns/10ps
`default_nettype none
module ccm_chk
   import ccm_pkg::*;
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       clock_input_pin,
   input wire logic       cpu_clk,
   input wire logic       cpu_clk_rise,
   input wire logic       cpu_clk_fall,
   input wire logic       pll_enable,
   input wire logic [4:0] pll_factor,
   input wire logic       osc_amp_enable,
   input wire logic       cpu_on_pll,
   input wire logic [2:0] clk_mode
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [2:0] up_ff;
   logic [4:0] fac;
   logic       ext;
   assign ext = clk_mode == STRAP_DIRECT || clk_mode == STRAP_PRESC;
   // edges seen since reset release, saturating
   always_ff @(posedge aclk) begin
      if (!aresetn) up_ff <= 3'h0;
      else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
   end
   always_comb begin
      case (clk_mode)
         3'h7:    fac = 5'h04;
         3'h6:    fac = 5'h03;
         3'h5:    fac = 5'h08;
         3'h4:    fac = 5'h05;
         3'h2:    fac = 5'h0A;
         3'h0:    fac = 5'h10;
         default: fac = 5'h00;
      endcase
   end
   sequence in_rise;
      up_ff > 3'h4 && $rose(clock_input_pin) && clk_mode == STRAP_PRESC
         && !cpu_on_pll;
   endsequence
   mode_hold_a: assert property (
      up_ff != 3'h0 |-> $stable(clk_mode))
      else $error("clock mode moved after reset");
   amp_mode_a: assert property (
      up_ff != 3'h0 |-> osc_amp_enable == (clk_mode != STRAP_DIRECT))
      else $error("amplifier enable wrong for mode");
   factor_map_a: assert property (
      up_ff != 3'h0 |-> pll_factor == fac)
      else $error("pll factor wrong for mode");
   pll_mult_a: assert property (
      up_ff != 3'h0 && !ext |-> pll_enable && cpu_on_pll)
      else $error("multiply mode not on pll");
   rise_flag_a: assert property (
      up_ff != 3'h0 |-> cpu_clk_rise == (cpu_clk && !$past(cpu_clk)))
      else $error("rise flag wrong");
   fall_flag_a: assert property (
      up_ff != 3'h0 |-> cpu_clk_fall == (!cpu_clk && $past(cpu_clk)))
      else $error("fall flag wrong");
   direct_copy_a: assert property (
      up_ff > 3'h4 && clk_mode == STRAP_DIRECT && !cpu_on_pll
      |-> cpu_clk == $past(clock_input_pin, 3))
      else $error("direct clock does not follow input");
   presc_step_a: assert property (
      in_rise |-> ##[2:4] $changed(cpu_clk))
      else $error("prescaler missed an input edge");
   fail_stick_a: assert property (
      cpu_on_pll && ext |=> cpu_on_pll)
      else $error("switched back from pll clock");
endmodule
bind ccm_top ccm_chk u_chk (.*);
`default_nettype wire

// >>> ccm_osc_wdog.sv
// oscillator watchdog: counts pll ticks between input clock transitions
`timescale 1ns/10ps
`default_nettype none
module ccm_osc_wdog
   import ccm_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   ccm_wd_if.wdog    wd
);
   typedef struct packed {
      logic [4:0] cnt;
      logic       fail;
   } ccm_wd_st_t;

   ccm_wd_st_t st_ff;
   ccm_wd_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (!aresetn) begin
         nxt_st = '0;
      end else if (st_ff.fail) begin
         // latched until the next reset
         nxt_st.fail = 1'b1;
      end else if (!wd.wd_run || wd.xtal_edge) begin
         nxt_st.cnt = '0;
      end else if (wd.pll_tick) begin
         if (st_ff.cnt == 5'(WD_OVF_CNT - 5'h01)) begin
            nxt_st.fail = 1'b1;
            nxt_st.cnt  = '0;
         end else begin
            nxt_st.cnt = 5'(st_ff.cnt + 5'h01);
         end
      end
   end

   always_ff @(posedge aclk) begin
      st_ff <= nxt_st;
   end

   assign wd.wd_fail = st_ff.fail;
endmodule
`default_nettype wire

// >>> ccm_pkg.sv
// constants, register map and factor decode function of the cpu clock mode selector
package ccm_pkg;

   // strap codes latched during reset
   localparam logic [2:0] STRAP_X4     = 3'h7;
   localparam logic [2:0] STRAP_X3     = 3'h6;
   localparam logic [2:0] STRAP_X8     = 3'h5;
   localparam logic [2:0] STRAP_X5     = 3'h4;
   localparam logic [2:0] STRAP_DIRECT = 3'h3;
   localparam logic [2:0] STRAP_X10    = 3'h2;
   localparam logic [2:0] STRAP_PRESC  = 3'h1;
   localparam logic [2:0] STRAP_X16    = 3'h0;

   // pll multiplication factors
   localparam logic [4:0] FACT_NONE = 5'h00;
   localparam logic [4:0] FACT_X3   = 5'h03;
   localparam logic [4:0] FACT_X4   = 5'h04;
   localparam logic [4:0] FACT_X5   = 5'h05;
   localparam logic [4:0] FACT_X8   = 5'h08;
   localparam logic [4:0] FACT_X10  = 5'h0A;
   localparam logic [4:0] FACT_X16  = 5'h10;

   // free-running pll half period in aclk cycles, watchdog overflow count
   localparam logic [3:0] PLL_HALF_CNT = 4'h2;
   localparam logic [4:0] WD_OVF_CNT   = 5'h10;

   // register byte addresses
   localparam logic [7:0] ADDR_SYSCFG  = 8'h00;
   localparam logic [7:0] ADDR_CLKSTAT = 8'h04;
   localparam logic [7:0] ADDR_IRQSTAT = 8'h08;
   localparam logic [7:0] ADDR_IRQCLR  = 8'h0C;
   localparam logic [7:0] ADDR_IRQEN   = 8'h10;

   // field positions
   localparam int OWD_DIS_BIT  = 4;
   localparam int ST_MODE_LSB  = 0;
   localparam int ST_PLL_BIT   = 3;
   localparam int ST_AMP_BIT   = 4;
   localparam int ST_ONPLL_BIT = 5;
   localparam int IRQ_OWD_BIT  = 0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic [4:0] ccm_factor(input logic [2:0] code);
      logic [4:0] f;
      f = FACT_NONE;
      case (code)
         STRAP_X4:  f = FACT_X4;
         STRAP_X3:  f = FACT_X3;
         STRAP_X8:  f = FACT_X8;
         STRAP_X5:  f = FACT_X5;
         STRAP_X10: f = FACT_X10;
         STRAP_X16: f = FACT_X16;
         default:   f = FACT_NONE;
      endcase
      return f;
   endfunction

endpackage

// >>> ccm_pll_osc.sv
// free-running pll clock model, stopped while the pll is off
`timescale 1ns/10ps
`default_nettype none
module ccm_pll_osc
   import ccm_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   ccm_wd_if.pll     wd
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       clk;
      logic       tick;
   } ccm_pll_st_t;

   ccm_pll_st_t st_ff;
   ccm_pll_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (!aresetn) begin
         nxt_st = '0;
      end else if (!wd.pll_on) begin
         nxt_st.cnt = '0;
         nxt_st.clk = 1'b0;
      end else if (st_ff.cnt == 4'(PLL_HALF_CNT - 4'h1)) begin
         nxt_st.cnt  = '0;
         nxt_st.clk  = ~st_ff.clk;
         nxt_st.tick = ~st_ff.clk;
      end else begin
         nxt_st.cnt = 4'(st_ff.cnt + 4'h1);
      end
   end

   always_ff @(posedge aclk) begin
      st_ff <= nxt_st;
   end

   assign wd.pll_clk  = st_ff.clk;
   assign wd.pll_tick = st_ff.tick;
endmodule
`default_nettype wire

// >>> ccm_top.sv
// cpu clock mode selector with oscillator watchdog and axi4-lite registers
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Function
// - sample the three strap pins during reset to choose clock mode
// - decode strap code into x4,x3,x8,x5,direct,x10,/2,x16
// - code 001 makes cpu clock from input by a 2:1 prescaler
// - in prescaler mode each cpu clock phase lasts one input period
// - code 011 takes cpu clock off the pll, bypasses amplifier, uses input pin
// - direct drive cpu clock follows input frequency and duty cycle
// - direct drive: two consecutive half periods equal one input period
// - both cpu clock edges are flagged for internal and external use
// - prescaler/direct with watchdog enabled keeps pll free running
// - prescaler/direct with watchdog disabled switches the pll off
// - oscillator amplifier enabled in every mode but direct drive
// - watchdog enabled at reset, disabled by config register bit 4
// - 16 pll ticks without input edge switch to pll and flag irq
module ccm_top
   import ccm_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [2:0]  clock_strap_pins,
   input  wire logic        clock_input_pin,
   output logic             cpu_clk,
   output logic             cpu_clk_rise,
   output logic             cpu_clk_fall,
   output logic             pll_enable,
   output logic [4:0]       pll_factor,
   output logic             osc_amp_enable,
   output logic             cpu_on_pll,
   output logic [2:0]       clk_mode,
   output logic             irq
);
   typedef struct packed {
      logic [2:0]  strap_s1;
      logic [2:0]  strap_s2;
      logic [2:0]  mode;
      logic        xin_s1;
      logic        xin_s2;
      logic        xin_s3;
      logic        cpu_clk;
      logic        cpu_rise;
      logic        cpu_fall;
      logic        pll_en;
      logic [4:0]  factor;
      logic        amp_en;
      logic        on_pll;
      logic        wd_run;
      logic        owd_dis;
      logic        fail_q;
      logic        irq_stat;
      logic        irq_en;
      logic        irq;
      logic [7:0]  awaddr;
      logic        aw_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        w_got;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ccm_st_t;

   ccm_st_t st_ff;
   ccm_st_t nxt_st;

   ccm_wd_if wdl ();

   ccm_pll_osc u_pll (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wd      (wdl.pll)
   );

   ccm_osc_wdog u_wdog (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wd      (wdl.wdog)
   );

   logic xin_edge;
   logic xin_rise;
   logic presc_or_direct;
   logic fail_evt;
   logic do_write;
   logic clr_owd;

   assign xin_edge = st_ff.xin_s2 ^ st_ff.xin_s3;
   assign xin_rise = st_ff.xin_s2 & ~st_ff.xin_s3;
   assign presc_or_direct = (st_ff.mode == STRAP_DIRECT) ||
                            (st_ff.mode == STRAP_PRESC);
   assign fail_evt = wdl.wd_fail & ~st_ff.fail_q;
   assign do_write = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
   assign clr_owd  = do_write && (st_ff.awaddr == ADDR_IRQCLR) &&
                     st_ff.wstrb[0] && st_ff.wdata[IRQ_OWD_BIT];

   assign wdl.xtal_edge = xin_edge;
   assign wdl.pll_on    = st_ff.pll_en;
   assign wdl.wd_run    = st_ff.wd_run;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.cpu_rise = 1'b0;
      nxt_st.cpu_fall = 1'b0;
      // synchronisers run in and out of reset
      nxt_st.strap_s1 = clock_strap_pins;
      nxt_st.strap_s2 = st_ff.strap_s1;
      nxt_st.xin_s1   = clock_input_pin;
      nxt_st.xin_s2   = st_ff.xin_s1;
      nxt_st.xin_s3   = st_ff.xin_s2;
      if (!aresetn) begin
         nxt_st.mode     = st_ff.strap_s2;
         nxt_st.cpu_clk  = 1'b0;
         nxt_st.pll_en   = 1'b0;
         nxt_st.factor   = FACT_NONE;
         nxt_st.amp_en   = 1'b0;
         nxt_st.on_pll   = 1'b0;
         nxt_st.wd_run   = 1'b0;
         nxt_st.owd_dis  = 1'b0;
         nxt_st.fail_q   = 1'b0;
         nxt_st.irq_stat = 1'b0;
         nxt_st.irq_en   = 1'b0;
         nxt_st.irq      = 1'b0;
         nxt_st.awaddr   = '0;
         nxt_st.aw_got   = 1'b0;
         nxt_st.wdata    = '0;
         nxt_st.wstrb    = '0;
         nxt_st.w_got    = 1'b0;
         nxt_st.awready  = 1'b0;
         nxt_st.wready   = 1'b0;
         nxt_st.bvalid   = 1'b0;
         nxt_st.bresp    = RESP_OKAY;
         nxt_st.arready  = 1'b0;
         nxt_st.rvalid   = 1'b0;
         nxt_st.rdata    = '0;
         nxt_st.rresp    = RESP_OKAY;
      end else begin
         // mode stays as latched until the next reset
         nxt_st.mode   = st_ff.mode;
         nxt_st.factor = ccm_factor(st_ff.mode);
         nxt_st.fail_q = wdl.wd_fail;
         nxt_st.on_pll = !presc_or_direct || wdl.wd_fail;
         // amplifier bypassed only for direct drive
         nxt_st.amp_en = (st_ff.mode != STRAP_DIRECT);
         nxt_st.wd_run = presc_or_direct && !st_ff.owd_dis;
         if (!presc_or_direct || wdl.wd_fail) begin
            nxt_st.pll_en = 1'b1;
         end else begin
            // watchdog clock when enabled, off otherwise
            nxt_st.pll_en = !st_ff.owd_dis;
         end

         // cpu clock source
         if (st_ff.on_pll) begin
            nxt_st.cpu_clk = wdl.pll_clk;
         end else if (st_ff.mode == STRAP_DIRECT) begin
            // each phase follows the input phase exactly
            nxt_st.cpu_clk = st_ff.xin_s2;
         end else if (xin_rise) begin
            // toggles once per input period, duty cycle independent
            nxt_st.cpu_clk = ~st_ff.cpu_clk;
         end
         nxt_st.cpu_rise = nxt_st.cpu_clk & ~st_ff.cpu_clk;
         nxt_st.cpu_fall = ~nxt_st.cpu_clk & st_ff.cpu_clk;

         // write channel capture, either order
         if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.awaddr = s_axi_awaddr;
            nxt_st.aw_got = 1'b1;
         end
         if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
            nxt_st.w_got = 1'b1;
         end
         if (do_write) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = RESP_OKAY;
            if (st_ff.awaddr == ADDR_SYSCFG) begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.owd_dis = st_ff.wdata[OWD_DIS_BIT];
               end
            end else if (st_ff.awaddr == ADDR_IRQEN) begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.irq_en = st_ff.wdata[IRQ_OWD_BIT];
               end
            end else if (st_ff.awaddr == ADDR_CLKSTAT ||
                         st_ff.awaddr == ADDR_IRQSTAT ||
                         st_ff.awaddr == ADDR_IRQCLR) begin
               nxt_st.bresp = RESP_OKAY;
            end else begin
               nxt_st.bresp = RESP_SLVERR;
            end
         end else if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
         end
         nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
         nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

         // sticky status, a new event beats a clear in the same cycle
         if (fail_evt) begin
            nxt_st.irq_stat = 1'b1;
         end else if (clr_owd) begin
            nxt_st.irq_stat = 1'b0;
         end
         nxt_st.irq = nxt_st.irq_stat && nxt_st.irq_en;

         // read channel
         if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = RESP_OKAY;
            nxt_st.rdata  = '0;
            if (s_axi_araddr == ADDR_SYSCFG) begin
               nxt_st.rdata[OWD_DIS_BIT] = st_ff.owd_dis;
            end else if (s_axi_araddr == ADDR_CLKSTAT) begin
               nxt_st.rdata[ST_MODE_LSB +: 3] = st_ff.mode;
               nxt_st.rdata[ST_PLL_BIT]       = st_ff.pll_en;
               nxt_st.rdata[ST_AMP_BIT]       = st_ff.amp_en;
               nxt_st.rdata[ST_ONPLL_BIT]     = st_ff.on_pll;
            end else if (s_axi_araddr == ADDR_IRQSTAT) begin
               nxt_st.rdata[IRQ_OWD_BIT] = st_ff.irq_stat;
            end else if (s_axi_araddr == ADDR_IRQEN) begin
               nxt_st.rdata[IRQ_OWD_BIT] = st_ff.irq_en;
            end else if (s_axi_araddr == ADDR_IRQCLR) begin
               nxt_st.rdata = '0;
            end else begin
               nxt_st.rresp = RESP_SLVERR;
            end
         end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
         end
         nxt_st.arready = !nxt_st.rvalid;
      end
   end

   always_ff @(posedge aclk) begin
      st_ff <= nxt_st;
   end

   assign s_axi_awready  = st_ff.awready;
   assign s_axi_wready   = st_ff.wready;
   assign s_axi_bresp    = st_ff.bresp;
   assign s_axi_bvalid   = st_ff.bvalid;
   assign s_axi_arready  = st_ff.arready;
   assign s_axi_rdata    = st_ff.rdata;
   assign s_axi_rresp    = st_ff.rresp;
   assign s_axi_rvalid   = st_ff.rvalid;
   assign cpu_clk        = st_ff.cpu_clk;
   assign cpu_clk_rise   = st_ff.cpu_rise;
   assign cpu_clk_fall   = st_ff.cpu_fall;
   assign pll_enable     = st_ff.pll_en;
   assign pll_factor     = st_ff.factor;
   assign osc_amp_enable = st_ff.amp_en;
   assign cpu_on_pll     = st_ff.on_pll;
   assign clk_mode       = st_ff.mode;
   assign irq            = st_ff.irq;
endmodule
`default_nettype wire

// >>> ccm_wd_if.sv
// link between controller, free-running pll model and oscillator watchdog
`timescale 1ns/10ps
`default_nettype none
interface ccm_wd_if;
   logic pll_on;
   logic pll_clk;
   logic pll_tick;
   logic wd_run;
   logic xtal_edge;
   logic wd_fail;

   modport pll  (input pll_on, output pll_clk, output pll_tick);
   modport wdog (input wd_run, input xtal_edge, input pll_tick,
                 output wd_fail);
   modport ctrl (output pll_on, output wd_run, output xtal_edge,
                 input pll_clk, input pll_tick, input wd_fail);
endinterface
`default_nettype wire

// >>> ccm_xtal_model.sv
// crystal or external clock source model driving the clock input pin
`timescale 1ns/10ps
`default_nettype none
module ccm_xtal_model (
   input  wire logic       aclk,
   input  wire logic       run,
   input  wire logic [3:0] hi_cyc,
   input  wire logic [3:0] lo_cyc,
   output var  logic       clock_input_pin
);
   logic [3:0] cnt;
   initial begin
      cnt = 4'h0;
      clock_input_pin = 1'b0;
   end
   // edges sit mid-cycle; a failed source holds its level
   always @(negedge aclk) begin
      if (run) begin
         if (cnt >= (clock_input_pin ? hi_cyc : lo_cyc) - 4'h1) begin
            cnt <= 4'h0;
            clock_input_pin <= ~clock_input_pin;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench of the cpu clock mode selector
`timescale 1ns/10ps
`default_nettype none
module tb
   import ccm_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, run;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, irq;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, clock_input_pin;
   logic cpu_clk, cpu_clk_rise, cpu_clk_fall, pll_enable, osc_amp_enable;
   logic cpu_on_pll;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb, hi_cyc, lo_cyc;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0]  clock_strap_pins, clk_mode;
   logic [4:0]  pll_factor;
   int          bad_count, n_tests, hi, lo;
   typedef struct {logic [2:0] c; logic [4:0] f; logic a, p;} ccm_row_t;
   ccm_row_t rows [8] = '{
      '{3'h7, 5'h04, 1'b1, 1'b1}, '{3'h6, 5'h03, 1'b1, 1'b1},
      '{3'h5, 5'h08, 1'b1, 1'b1}, '{3'h4, 5'h05, 1'b1, 1'b1},
      '{3'h3, 5'h00, 1'b0, 1'b0}, '{3'h2, 5'h0A, 1'b1, 1'b1},
      '{3'h1, 5'h00, 1'b1, 1'b0}, '{3'h0, 5'h10, 1'b1, 1'b1}};
   ccm_top dut (.*);
   ccm_xtal_model xm (.aclk, .run, .hi_cyc, .lo_cyc, .clock_input_pin);
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic hang();
      bad_count++;
      test_done();
   endtask
   // waits on irq when on_irq is high, on pll_enable otherwise
   task automatic wait_v(input logic on_irq, input logic v);
      int n;
      for (n = 0; n < 200 && (on_irq ? irq : pll_enable) !== v; n++)
         @(posedge aclk);
      if ((on_irq ? irq : pll_enable) !== v) hang();
   endtask
   task automatic rst(input logic [2:0] c);
      clock_strap_pins <= c;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (ad && wd && s_axi_bvalid) break;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         ad = ad | s_axi_awready;
         wd = wd | s_axi_wready;
      end
      if (n == 99) hang();
      rsp = s_axi_bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (s_axi_rvalid) break;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (n == 99) hang();
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   // cycles of one cpu clock high phase and the low phase after it
   task automatic phases();
      int n;
      for (n = 0; n < 99 && cpu_clk_rise !== 1'b1; n++) @(posedge aclk);
      for (hi = 0; hi < 99 && (hi == 0 || cpu_clk_fall !== 1'b1); hi++)
         @(posedge aclk);
      for (lo = 0; lo < 99 && (lo == 0 || cpu_clk_rise !== 1'b1); lo++)
         @(posedge aclk);
      if (n == 99 || hi == 99 || lo == 99) hang();
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, aresetn} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      clock_strap_pins = 3'h7;
      run = 1'b1;
      hi_cyc = 4'h2;
      lo_cyc = 4'h4;
      foreach (rows[i]) begin
         rst(rows[i].c);
         chk(clk_mode, rows[i].c);
         chk(pll_factor, rows[i].f);
         chk(osc_amp_enable, rows[i].a);
         chk(pll_enable, 1'b1);
         chk(cpu_on_pll, rows[i].p);
         rdr(ADDR_CLKSTAT);
         chk(rd, {26'h0, rows[i].p, rows[i].a, 1'b1, rows[i].c});
         rdr(ADDR_SYSCFG);
         chk(rd, 32'h0);
      end
      $display("mode table test end");
      rst(STRAP_DIRECT);
      phases();
      chk(hi, 2);
      chk(lo, 4);
      chk(hi + lo, 6);
      rst(STRAP_PRESC);
      phases();
      chk(hi, 6);
      chk(lo, 6);
      clock_strap_pins <= 3'h7;
      wr(ADDR_SYSCFG, 32'h10);
      wait_v(1'b0, 1'b0);
      chk(pll_enable, 1'b0);
      rdr(ADDR_SYSCFG);
      chk(rd, 32'h10);
      chk(clk_mode, STRAP_PRESC);
      wr(ADDR_SYSCFG, 32'h0);
      wait_v(1'b0, 1'b1);
      chk(pll_enable, 1'b1);
      $display("direct and prescaler test end");
      rst(STRAP_DIRECT);
      wr(ADDR_IRQEN, 32'h1);
      run <= 1'b0;
      // sixteen pll ticks of four cycles cannot elapse within forty
      repeat (40) @(posedge aclk);
      chk(cpu_on_pll, 1'b0);
      wait_v(1'b1, 1'b1);
      chk(cpu_on_pll, 1'b1);
      rdr(ADDR_IRQSTAT);
      chk(rd, 32'h1);
      run <= 1'b1;
      phases();
      chk(hi + lo, 4);
      chk(cpu_on_pll, 1'b1);
      wr(ADDR_IRQEN, 32'h0);
      wait_v(1'b1, 1'b0);
      wr(ADDR_IRQCLR, 32'h1);
      wr(ADDR_IRQEN, 32'h1);
      rdr(ADDR_IRQSTAT);
      chk(rd, 32'h0);
      chk(irq, 1'b0);
      rdr(8'h20);
      chk(rsp, RESP_SLVERR);
      chk(rd, 32'h0);
      wr(8'h24, 32'h1);
      chk(rsp, RESP_SLVERR);
      wr(ADDR_CLKSTAT, 32'hFF);
      chk(rsp, RESP_OKAY);
      rst(STRAP_DIRECT);
      chk(cpu_on_pll, 1'b0);
      $display("watchdog and bus test end");
      test_done();
   end
endmodule
`default_nettype wire
